// ===== hdl/cte_pkg.sv
// constants and types shared by the transmit error state block
package cte_pkg;
    // register widths, reset values and the message status read opcode
    localparam int TEC_W = 8;
    localparam logic [7:0] TEC_RESET = 8'h00;
    localparam logic [7:0] OPC_MSG_STATUS = 8'hda;
    // error state thresholds
    localparam logic [8:0] WARN_MIN = 9'h060;     // 96
    localparam logic [8:0] PASSIVE_MIN = 9'h080;  // 128
    localparam logic [8:0] BUS_DISCONNECTED_FLAG_MIN = 9'h100;   // above 255
    // count steps of fault confinement
    localparam logic [8:0] TX_ERR_STEP = 9'h008;
    localparam logic [8:0] TX_OK_STEP = 9'h001;
    // bus-off recovery: 128 runs of 11 recessive bits
    localparam logic [3:0] RUN_BITS = 4'hb;
    localparam logic [7:0] RUN_COUNT = 8'h80;
    // bit positions in status flag and error registers
    localparam int STATUS_FLAG_REGISTER_WARN_BIT = 0;
    localparam int STATUS_FLAG_REGISTER_PASSIVE_BIT = 1;
    localparam int STATUS_FLAG_REGISTER_BUS_DISCONNECTED_FLAG_BIT = 2;
    localparam int ERR_TXPASSIVE_BIT = 0;
    localparam int ERR_BUS_DISCONNECTED_FLAG_BIT = 1;
    // message status layout
    localparam int MSGST_HIT_LSB = 4;
    localparam int MSGST_TX_LSB = 0;
    typedef enum logic [1:0] {CTE_ACTIVE, CTE_PASSIVE, CTE_BUS_DISCONNECTED_FLAG} cte_state_e;
endpackage : cte_pkg

// ===== hdl/cte_rec_if.sv
// carrier between the state logic and the recovery counter
`timescale 1ns/1ns
`default_nettype none
interface cte_rec_if;
    logic arm;
    logic bit_tick;
    logic recessive;
    logic done;
    modport ctl (output arm, output bit_tick, output recessive, input done);
    modport cnt (input arm, input bit_tick, input recessive, output done);
endinterface : cte_rec_if
`default_nettype wire

// ===== hdl/cte_recovery.sv
// counter of recessive runs that ends bus-off
`timescale 1ns/1ns
`default_nettype none
module cte_recovery (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    cte_rec_if.cnt rec
);
    logic [3:0] bit_run;
    logic [7:0] run_cnt;

    // count recessive bits; a dominant bit restarts the current run
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !rec.arm) begin
            bit_run <= 4'h0;
            run_cnt <= 8'h00;
        end else if (rec.bit_tick) begin
            if (!rec.recessive) begin
                bit_run <= 4'h0;
            end else if (bit_run == cte_pkg::RUN_BITS - 4'h1) begin
                bit_run <= 4'h0;
                if (run_cnt != cte_pkg::RUN_COUNT) begin
                    run_cnt <= run_cnt + 8'h01;
                end
            end else begin
                bit_run <= bit_run + 4'h1;
            end
        end
    end

    assign rec.done = (run_cnt == cte_pkg::RUN_COUNT);
endmodule // cte_recovery
`default_nettype wire

// ===== hdl/cte_tx_error_state.sv
// transmit error count, error state flags and message status
`timescale 1ns/1ns
`default_nettype none
module cte_tx_error_state (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_tx_error,
    input wire logic i_tx_success,
    input wire logic i_count_wr,
    input wire logic [7:0] i_count_wdata,
    input wire logic i_host_recover,
    input wire logic i_auto_recovery_enable,
    input wire logic i_warning_irq_enable,
    input wire logic i_passive_irq_enable,
    input wire logic i_bus_disconnected_irq_enable,
    input wire logic i_bit_tick,
    input wire logic i_rx_bit,
    input wire logic [7:0] i_filter_match,
    input wire logic i_rx_valid,
    input wire logic [3:0] i_tx_status,
    input wire logic [7:0] i_rd_opcode,
    output logic [7:0] o_transmit_error_count,
    output logic [2:0] o_status_flag_register,
    output logic [1:0] o_error_register,
    output logic [7:0] o_message_status,
    output logic [7:0] o_rd_data,
    output logic o_irq
);
    cte_pkg::cte_state_e state;
    cte_pkg::cte_state_e next_state;
    logic [8:0] count9;
    logic [8:0] next_count9;
    logic [3:0] hit;
    logic [3:0] next_hit;
    logic [3:0] tx_status_q;
    logic rx_meta;
    logic rx_sync;
    logic recover_now;
    logic [7:0] msg_word;
    cte_rec_if rec ();

    // lowest index match wins, leading one marks a hit
    function automatic logic [3:0] hit_code(input logic [7:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // error band of a count; shared by the write path and the event path
    function automatic cte_pkg::cte_state_e band_of(input logic [8:0] c);
        cte_pkg::cte_state_e s;
        if (c >= cte_pkg::BUS_DISCONNECTED_FLAG_MIN) begin
            s = cte_pkg::CTE_BUS_DISCONNECTED_FLAG;
        end else if (c >= cte_pkg::PASSIVE_MIN) begin
            s = cte_pkg::CTE_PASSIVE;
        end else begin
            s = cte_pkg::CTE_ACTIVE;
        end
        return s;
    endfunction

    // bus level comes from the pin side, so synchronise it first
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= i_rx_bit;
            rx_sync <= rx_meta;
        end
    end

    // fault confinement steps; saturate at the bus-off boundary
    always_comb begin
        next_count9 = count9;
        if (i_tx_error) begin
            next_count9 = count9 + cte_pkg::TX_ERR_STEP;
        end else if (i_tx_success && count9 != 9'h000) begin
            next_count9 = count9 - cte_pkg::TX_OK_STEP;
        end
        if (next_count9 > cte_pkg::BUS_DISCONNECTED_FLAG_MIN) begin
            next_count9 = cte_pkg::BUS_DISCONNECTED_FLAG_MIN;
        end
    end

    // count register; host test write has priority over bus events
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            count9 <= {1'b0, cte_pkg::TEC_RESET};
        end else if (i_count_wr) begin
            count9 <= {1'b0, i_count_wdata};
        end else if (state == cte_pkg::CTE_BUS_DISCONNECTED_FLAG) begin
            // bus-off holds the count until a recovery clears it
            if (recover_now) begin
                count9 <= 9'h000;
            end
        end else begin
            count9 <= next_count9;
        end
    end

    // recovery only counts in bus-off: enabled auto recovery, or the host
    assign recover_now = (i_auto_recovery_enable && rec.done) || i_host_recover;

    // next error state; a host write outranks a recovery, as it does for the count
    always_comb begin
        next_state = state;
        unique case (state)
            cte_pkg::CTE_BUS_DISCONNECTED_FLAG: begin
                if (i_count_wr) begin
                    next_state = band_of({1'b0, i_count_wdata});
                end else if (recover_now) begin
                    next_state = cte_pkg::CTE_ACTIVE;
                end
            end
            default: begin
                if (i_count_wr) begin
                    next_state = band_of({1'b0, i_count_wdata});
                end else begin
                    next_state = band_of(next_count9);
                end
            end
        endcase
    end

    // error state register; state and count move on the same edge
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            state <= cte_pkg::CTE_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // recovery counter runs only while bus-off with auto recovery on
    assign rec.arm = (state == cte_pkg::CTE_BUS_DISCONNECTED_FLAG) && i_auto_recovery_enable;
    assign rec.bit_tick = i_bit_tick;
    assign rec.recessive = rx_sync;

    cte_recovery u_recovery (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .rec(rec)
    );

    // filter hit latched per valid message, tx status sampled each cycle
    always_comb begin
        next_hit = hit_code(i_filter_match);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            hit <= 4'h0;
            tx_status_q <= 4'h0;
        end else begin
            if (i_rx_valid) begin
                hit <= next_hit;
            end
            tx_status_q <= i_tx_status;
        end
    end

    // message status word as the host reads it
    assign msg_word = {hit, tx_status_q};

    // flags follow the state; in bus-off the low count byte reads zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_transmit_error_count <= cte_pkg::TEC_RESET;
            o_status_flag_register <= 3'h0;
            o_error_register <= 2'h0;
            o_message_status <= 8'h00;
        end else begin
            o_transmit_error_count <= count9[7:0];
            o_status_flag_register[cte_pkg::STATUS_FLAG_REGISTER_WARN_BIT] <=
                (state == cte_pkg::CTE_ACTIVE) && (count9 >= cte_pkg::WARN_MIN);
            o_status_flag_register[cte_pkg::STATUS_FLAG_REGISTER_PASSIVE_BIT] <=
                (state == cte_pkg::CTE_PASSIVE);
            o_status_flag_register[cte_pkg::STATUS_FLAG_REGISTER_BUS_DISCONNECTED_FLAG_BIT] <=
                (state == cte_pkg::CTE_BUS_DISCONNECTED_FLAG);
            o_error_register[cte_pkg::ERR_TXPASSIVE_BIT] <=
                (state == cte_pkg::CTE_PASSIVE);
            o_error_register[cte_pkg::ERR_BUS_DISCONNECTED_FLAG_BIT] <=
                (state == cte_pkg::CTE_BUS_DISCONNECTED_FLAG);
            o_message_status <= msg_word;
        end
    end

    // read port: message status opcode, otherwise the count
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= (i_rd_opcode == cte_pkg::OPC_MSG_STATUS)
                ? msg_word : count9[7:0];
        end
    end

    // interrupt built from the registered flags, so it trails them by one edge
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (o_status_flag_register[cte_pkg::STATUS_FLAG_REGISTER_WARN_BIT] && i_warning_irq_enable)
                || (o_status_flag_register[cte_pkg::STATUS_FLAG_REGISTER_PASSIVE_BIT] && i_passive_irq_enable)
                || (o_status_flag_register[cte_pkg::STATUS_FLAG_REGISTER_BUS_DISCONNECTED_FLAG_BIT]
                    && i_bus_disconnected_irq_enable);
        end
    end
endmodule // cte_tx_error_state
`default_nettype wire

// ===== verification/cte_host_model.sv
// host side model that restores the block from bus-off itself
`timescale 1ns/1ns
`default_nettype none
module cte_host_model (
    input wire logic i_ref_clk,
    input wire logic i_manage,
    input wire logic i_bus_off,
    output logic o_recover
);
    // single pulses, since the flag needs a few edges to drop
    initial o_recover = 1'b0;
    always @(negedge i_ref_clk) begin
        o_recover <= i_manage && i_bus_off && !o_recover;
    end
endmodule // cte_host_model
`default_nettype wire

// ===== verification/cte_tx_error_state_assertions.sv
// port assertions of the transmit error state block
`timescale 1ns/1ns
`default_nettype none
module cte_tx_error_state_assertions (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_count_wr,
    input wire logic [7:0] i_count_wdata,
    input wire logic i_host_recover,
    input wire logic i_auto_recovery_enable,
    input wire logic i_warning_irq_enable,
    input wire logic i_passive_irq_enable,
    input wire logic i_bus_disconnected_irq_enable,
    input wire logic i_rx_valid,
    input wire logic [7:0] o_transmit_error_count,
    input wire logic [2:0] o_status_flag_register,
    input wire logic [1:0] o_error_register,
    input wire logic [7:0] o_message_status,
    input wire logic o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // warning and passive flags are pure functions of the count as it reads; the bus-off flag only implies a zero count
    a_count_write: assert property (i_count_wr |-> ##2 o_transmit_error_count == $past(i_count_wdata, 2))
        else $error("count write not taken");
    a_warn_band: assert property (o_status_flag_register[0] == (o_transmit_error_count >= 8'h60 && o_transmit_error_count <= 8'h7f))
        else $error("warning flag off its band");
    a_passive_pair: assert property (o_error_register[0] == o_transmit_error_count[7] && o_status_flag_register[1] == o_error_register[0])
        else $error("passive flags disagree");
    a_bus_disconnected_flag_pair: assert property (o_error_register[1] == o_status_flag_register[2] && (!o_error_register[1] || o_transmit_error_count == 8'h00))
        else $error("bus-off flags disagree");
    a_irq_gate: assert property (o_irq == $past(|(o_status_flag_register & {i_bus_disconnected_irq_enable, i_passive_irq_enable, i_warning_irq_enable})))
        else $error("interrupt not gated by enables");
    // bus-off may only end through host action or enabled auto recovery
    a_no_self_recover: assert property ($fell(o_error_register[1]) |-> $past(i_host_recover, 2) || $past(i_count_wr, 2) || $past(i_auto_recovery_enable, 2))
        else $error("bus-off left without cause");
    a_hit_held: assert property (!$past(i_rx_valid) && !$past(i_rx_valid, 2) |-> $stable(o_message_status[7:4]))
        else $error("filter hit moved without valid");
    a_hit_form: assert property (o_message_status[7:4] == 4'h0 || o_message_status[7])
        else $error("filter hit lacks leading one");
    a_reset_zero: assert property (disable iff (1'b0) !i_rst_b |=> o_transmit_error_count == 8'h00 && o_irq == 1'b0)
        else $error("count not cleared by reset");
    c_bus_disconnected_flag: cover property (o_error_register[1]);
    c_irq: cover property (o_irq);
    c_auto: cover property ($fell(o_error_register[1]) && i_auto_recovery_enable);
endmodule // cte_tx_error_state_assertions
`default_nettype wire

// ===== verification/cte_tx_error_state_bench.sv
// self-checking bench of the transmit error state block
`timescale 1ns/1ns
`default_nettype none
module cte_tx_error_state_bench;
    typedef struct {logic [7:0] v; logic [2:0] en; logic [2:0] st; logic [1:0] er; logic q;} cte_row_s;
    cte_row_s rows [8] = '{'{8'h5f, 3'h7, 3'h0, 2'h0, 1'h0}, '{8'h60, 3'h7, 3'h1, 2'h0, 1'h1},
        '{8'h60, 3'h6, 3'h1, 2'h0, 1'h0}, '{8'h7f, 3'h1, 3'h1, 2'h0, 1'h1},
        '{8'h80, 3'h2, 3'h2, 2'h1, 1'h1}, '{8'h80, 3'h5, 3'h2, 2'h1, 1'h0},
        '{8'hff, 3'h2, 3'h2, 2'h1, 1'h1}, '{8'h00, 3'h7, 3'h0, 2'h0, 1'h0}};
    logic i_ref_clk = 1'b0, i_rst_b = 1'b0, txe = 1'b0, txs = 1'b0, wr = 1'b0, auto = 1'b0;
    logic tick = 1'b0, rxb = 1'b1, rxv = 1'b0, manage = 1'b0, irq, rec;
    logic [7:0] wd = 8'h00, fm = 8'h00, opc = 8'h00, cnt, ms, rd;
    logic [2:0] en = 3'h0, st;
    logic [3:0] txst = 4'h0;
    logic [1:0] er;
    int bad_count = 0, total_checks = 0, cyc = 0;
    cte_tx_error_state uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_tx_error(txe),
        .i_tx_success(txs), .i_count_wr(wr), .i_count_wdata(wd), .i_host_recover(rec),
        .i_auto_recovery_enable(auto), .i_warning_irq_enable(en[0]), .i_passive_irq_enable(en[1]),
        .i_bus_disconnected_irq_enable(en[2]), .i_bit_tick(tick), .i_rx_bit(rxb),
        .i_filter_match(fm), .i_rx_valid(rxv), .i_tx_status(txst), .i_rd_opcode(opc),
        .o_transmit_error_count(cnt), .o_status_flag_register(st), .o_error_register(er),
        .o_message_status(ms), .o_rd_data(rd), .o_irq(irq));
    cte_host_model host (.i_ref_clk(i_ref_clk), .i_manage(manage), .i_bus_off(er[1]), .o_recover(rec));
    always #25 i_ref_clk = ~i_ref_clk;
    // hang guard, far above the few thousand cycles needed
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // one-cycle strobes, then room for the three-edge irq path
    task automatic pls(input logic e, input logic s, input logic w, input logic v);
        @(negedge i_ref_clk) {txe, txs, wr, rxv} = {e, s, w, v};
        @(negedge i_ref_clk) {txe, txs, wr, rxv} = 4'h0;
        repeat (4) @(negedge i_ref_clk);
    endtask
    task automatic run(input int n);
        repeat (n) @(negedge i_ref_clk) tick = 1'b1;
        @(negedge i_ref_clk) tick = 1'b0;
        repeat (4) @(negedge i_ref_clk);
    endtask
    initial begin
        repeat (8) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        chk("count", 8'h00, cnt);
        foreach (rows[k]) begin
            en = rows[k].en;
            wd = rows[k].v;
            pls(0, 0, 1, 0);
            chk("count", rows[k].v, cnt);
            chk("status", rows[k].st, st);
            chk("error", rows[k].er, er);
            chk("irq", rows[k].q, irq);
        end
        // success steps down by one, error wins over success
        wd = 8'h0a;
        pls(0, 0, 1, 0);
        pls(0, 1, 0, 0);
        chk("count", 8'h09, cnt);
        pls(1, 1, 0, 0);
        chk("count", 8'h11, cnt);
        // past 255 is bus-off, and success is then ignored
        en = 3'h4;
        wd = 8'hf8;
        pls(0, 0, 1, 0);
        pls(1, 0, 0, 0);
        pls(0, 1, 0, 0);
        chk("status", 8'h04, st);
        chk("error", 8'h02, er);
        chk("irq", 8'h01, irq);
        en = 3'h3;
        repeat (4) @(negedge i_ref_clk);
        chk("irq", 8'h00, irq);
        run(1500);
        chk("status", 8'h04, st);
        // non-blocking, so the host model sees the change one edge later for sure
        manage <= 1'b1;
        repeat (6) @(negedge i_ref_clk);
        manage <= 1'b0;
        chk("status", 8'h00, st);
        chk("count", 8'h00, cnt);
        pls(0, 0, 1, 0);
        pls(1, 0, 0, 0);
        auto = 1'b1;
        run(1400);
        chk("status", 8'h04, st);
        // a dominant bit restarts only the run in progress
        rxb = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        run(1);
        rxb = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        run(10);
        chk("status", 8'h04, st);
        run(1);
        chk("status", 8'h00, st);
        chk("count", 8'h00, cnt);
        // a host write out of bus-off lands in the band of the written value
        pls(0, 0, 1, 0);
        pls(1, 0, 0, 0);
        chk("status", 8'h04, st);
        wd = 8'h90;
        pls(0, 0, 1, 0);
        chk("status", 8'h02, st);
        chk("count", 8'h90, cnt);
        txst = 4'h5;
        fm = 8'h64;
        pls(0, 0, 0, 1);
        chk("msg", 8'ha5, ms);
        fm = 8'h80;
        pls(0, 0, 0, 1);
        chk("msg", 8'hf5, ms);
        fm = 8'h00;
        pls(0, 0, 0, 1);
        fm = 8'h01;
        repeat (4) @(negedge i_ref_clk);
        chk("msg", 8'h05, ms);
        opc = 8'hda;
        repeat (4) @(negedge i_ref_clk);
        chk("read", 8'h05, rd);
        wd = 8'h80;
        pls(0, 0, 1, 0);
        opc = 8'h00;
        repeat (4) @(negedge i_ref_clk);
        chk("read", 8'h80, rd);
        // reset in mid-run clears the count and every flag
        i_rst_b = 1'b0;
        repeat (8) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        chk("count", 8'h00, cnt);
        chk("status", 8'h00, st);
        chk("error", 8'h00, er);
        stop_test();
    end
endmodule // cte_tx_error_state_bench
bind cte_tx_error_state cte_tx_error_state_assertions chk_i (.*);
`default_nettype wire
